// ==== hdl/eep_read_protect.sv ====
// two-wire eeprom slave: reads, pointer, write protection and protection flag commands
// assumes scl/sda oversampled by core_clk; sda is open drain, pulled up outside
`timescale 1ns/1ps
`default_nettype none
`include "eep_params.svh"

module eep_read_protect #(
    parameter int WC_CYCLES = `EEP_WC_CYCLES  // internal write time in clocks
) (
    input  wire logic               core_clk,       // core clock, 200 mhz
    input  wire logic               rst_n,          // async reset, active low
    input  wire eep_pkg::eep_pins_t pins_i,         // bus, guard and select pins
    output logic                    sda_o,          // sda drive value, always low
    output logic                    sda_oe,         // high while pulling sda low
    output logic                    protect_flag_o, // software protection flag
    output logic                    busy_o          // programming cycle running
);
    import eep_pkg::*;

    localparam logic [7:0] HV_LIM = 8'(`EEP_HV_CYCLES);

    eep_pins_t  pins_s, pins_q_r;
    eep_state_t st_r, st_nxt;
    eep_phase_t ph_r, ph_nxt;
    eep_kind_t  kind_r, kind_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
    logic [7:0] waddr_r, waddr_nxt, wdata_r, wdata_nxt;
    logic [7:0] hv_cnt_r, hv_cnt_nxt;
    logic [`EEP_WC_W-1:0] busy_cnt_r, busy_cnt_nxt;
    logic       clr_mode_r, clr_mode_nxt, have_r, have_nxt, to_rd_r, to_rd_nxt;
    logic       flag_r, flag_nxt, drv_r, drv_nxt;
    logic [7:0] mem_r [256];
    logic       mem_we;
    logic       scl_rise, scl_fall, start_ev, stop_ev, byte_done, busy, hv_ok;
    logic       ack_ok, commit;
    logic [7:0] rx_byte;

    eep_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pins_i   (pins_i),
        .pins_o   (pins_s)
    );

    // sda only changes while scl is low on our side, so these never self-trigger
    assign scl_rise  = pins_s.scl & ~pins_q_r.scl;
    assign scl_fall  = ~pins_s.scl & pins_q_r.scl;
    assign start_ev  = pins_s.scl & pins_q_r.scl & pins_q_r.sda & ~pins_s.sda;
    assign stop_ev   = pins_s.scl & pins_q_r.scl & ~pins_q_r.sda & pins_s.sda;
    assign rx_byte   = {sh_r[6:0], pins_s.sda};
    assign byte_done = (st_r == ST_RX) && scl_rise && (cnt_r == 4'h7);
    assign busy      = (busy_cnt_r != '0);
    assign hv_ok     = (hv_cnt_r == HV_LIM);
    assign commit    = stop_ev && have_r && !busy;

    assign sda_o          = 1'b0;
    assign sda_oe         = drv_r;
    assign protect_flag_o = flag_r;
    assign busy_o         = busy;

    always_comb
    begin
        st_nxt       = st_r;
        ph_nxt       = ph_r;
        kind_nxt     = kind_r;
        cnt_nxt      = cnt_r;
        sh_nxt       = sh_r;
        tx_nxt       = tx_r;
        ptr_nxt      = ptr_r;
        waddr_nxt    = waddr_r;
        wdata_nxt    = wdata_r;
        clr_mode_nxt = clr_mode_r;
        have_nxt     = have_r;
        to_rd_nxt    = to_rd_r;
        flag_nxt     = flag_r;
        drv_nxt      = drv_r;
        ack_ok       = 1'b0;
        mem_we       = 1'b0;
        hv_cnt_nxt   = pins_s.wp_hv ? (hv_ok ? hv_cnt_r : hv_cnt_r + 8'h01) : 8'h00;
        busy_cnt_nxt = busy ? busy_cnt_r - `EEP_WC_W'(1) : busy_cnt_r;

        // byte decode; no answer at all while programming
        if (byte_done && !busy)
        begin
            unique case (ph_r)
                PH_LEAD, PH_CTRL:
                begin
                    if (ph_r == PH_LEAD && rx_byte[7:4] == `EEP_CODE_CLR)
                    begin
                        ack_ok       = hv_ok;
                        clr_mode_nxt = 1'b1;
                        ph_nxt       = PH_CTRL;
                    end
                    else if (rx_byte[3:1] == pins_s.sel)
                    begin
                        if (rx_byte[7:4] == `EEP_CODE_ARRAY && !clr_mode_r)
                        begin
                            ack_ok    = 1'b1;
                            to_rd_nxt = rx_byte[0];
                            kind_nxt  = K_ARRAY;
                            ph_nxt    = PH_ADDR;
                        end
                        else if (rx_byte[7:4] == `EEP_CODE_PROT && !rx_byte[0])
                        begin
                            // guard pin high refuses setting; set flag hides the code
                            ack_ok   = clr_mode_r || (!flag_r && !pins_s.wp);
                            kind_nxt = clr_mode_r ? K_CLR : K_SET;
                            ph_nxt   = PH_ADDR;
                        end
                    end
                end
                PH_ADDR:
                begin
                    ack_ok = 1'b1;
                    ph_nxt = PH_DATA;
                    if (kind_r == K_ARRAY)
                        ptr_nxt = rx_byte;
                end
                PH_DATA:
                begin
                    ack_ok    = 1'b1;
                    wdata_nxt = rx_byte;
                    waddr_nxt = ptr_r;
                    have_nxt  = 1'b1;
                    if (kind_r == K_ARRAY)
                        ptr_nxt = ptr_r + 8'h01;
                end
            endcase
        end

        unique case (st_r)
            ST_IDLE:
            begin
            end
            ST_RX:
            begin
                if (scl_rise)
                begin
                    sh_nxt  = rx_byte;
                    cnt_nxt = cnt_r + 4'h1;
                    if (byte_done)
                        st_nxt = ack_ok ? ST_RX_ACK : ST_IDLE;
                end
            end
            ST_RX_ACK:
            begin
                if (scl_fall && !drv_r)
                    drv_nxt = 1'b1;
                else if (scl_fall)
                begin
                    drv_nxt = 1'b0;
                    cnt_nxt = 4'h0;
                    st_nxt  = ST_RX;
                    if (to_rd_r)
                    begin
                        // pointer is last access plus one; 8 bits keep it in this device
                        tx_nxt  = mem_r[ptr_r];
                        drv_nxt = ~mem_r[ptr_r][7];
                        ptr_nxt = ptr_r + 8'h01;
                        st_nxt  = ST_TX;
                    end
                end
            end
            ST_TX:
            begin
                if (scl_rise)
                begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'h7)
                        st_nxt = ST_TX_ACK;
                end
                else if (scl_fall)
                begin
                    tx_nxt  = {tx_r[6:0], 1'b0};
                    drv_nxt = ~tx_r[6];
                end
            end
            ST_TX_ACK:
            begin
                if (scl_fall)
                    drv_nxt = 1'b0;
                else if (scl_rise)
                    st_nxt = pins_s.sda ? ST_IDLE : ST_TX_NEXT;
            end
            ST_TX_NEXT:
            begin
                if (scl_fall)
                begin
                    tx_nxt  = mem_r[ptr_r];
                    drv_nxt = ~mem_r[ptr_r][7];
                    ptr_nxt = ptr_r + 8'h01;
                    cnt_nxt = 4'h0;
                    st_nxt  = ST_TX;
                end
            end
        endcase

        // stop ends everything; with a data byte pending and not busy it starts the write cycle, even if protected
        if (stop_ev)
        begin
            st_nxt   = ST_IDLE;
            drv_nxt  = 1'b0;
            have_nxt = 1'b0;
            if (commit)
            begin
                busy_cnt_nxt = `EEP_WC_W'(WC_CYCLES);
                if (!pins_s.vcc_low)
                begin
                    unique case (kind_r)
                        K_ARRAY: mem_we = !pins_s.wp && !(flag_r && !waddr_r[`EEP_UPPER_BIT]);
                        K_SET:   flag_nxt = flag_r | !pins_s.wp;
                        K_CLR:   flag_nxt = 1'b0;
                    endcase
                end
            end
        end
        else if (start_ev)
        begin
            // restart drops pending data but keeps the loaded pointer
            st_nxt       = ST_RX;
            ph_nxt       = PH_LEAD;
            cnt_nxt      = 4'h0;
            drv_nxt      = 1'b0;
            have_nxt     = 1'b0;
            clr_mode_nxt = 1'b0;
            to_rd_nxt    = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_q_r   <= `EEP_PINS_RST;
            st_r       <= ST_IDLE;
            ph_r       <= PH_LEAD;
            kind_r     <= K_ARRAY;
            cnt_r      <= 4'h0;
            sh_r       <= 8'h00;
            tx_r       <= 8'h00;
            ptr_r      <= `EEP_PTR_RST;
            waddr_r    <= 8'h00;
            wdata_r    <= 8'h00;
            hv_cnt_r   <= 8'h00;
            busy_cnt_r <= '0;
            clr_mode_r <= 1'b0;
            have_r     <= 1'b0;
            to_rd_r    <= 1'b0;
            flag_r     <= `EEP_FLAG_RST;
            drv_r      <= 1'b0;
        end
        else
        begin
            pins_q_r   <= pins_s;
            st_r       <= st_nxt;
            ph_r       <= ph_nxt;
            kind_r     <= kind_nxt;
            cnt_r      <= cnt_nxt;
            sh_r       <= sh_nxt;
            tx_r       <= tx_nxt;
            ptr_r      <= ptr_nxt;
            waddr_r    <= waddr_nxt;
            wdata_r    <= wdata_nxt;
            hv_cnt_r   <= hv_cnt_nxt;
            busy_cnt_r <= busy_cnt_nxt;
            clr_mode_r <= clr_mode_nxt;
            have_r     <= have_nxt;
            to_rd_r    <= to_rd_nxt;
            flag_r     <= flag_nxt;
            drv_r      <= drv_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 256; g++)
        begin : g_mem
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    mem_r[g] <= `EEP_MEM_RST;
                else if (mem_we && waddr_r == 8'(g))
                    mem_r[g] <= wdata_r;
            end
        end
    endgenerate

    a_guard_blocks_array: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (commit && pins_s.wp) |=> (mem_r[$past(waddr_r)] == $past(mem_r[waddr_r])))
        else $error("array written while guard pin high");

    a_lower_half_locked: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (commit && kind_r == K_ARRAY && flag_r && !waddr_r[7]) |=> !$past(mem_we))
        else $error("lower half written while flag set");

    a_upper_half_open: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (commit && kind_r == K_ARRAY && waddr_r[7] && !pins_s.wp && !pins_s.vcc_low)
        |=> (mem_r[$past(waddr_r)] == $past(wdata_r)))
        else $error("upper half write lost with guard low");

    a_guard_no_flag: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!flag_r && pins_s.wp && kind_r == K_SET) |=> !flag_r)
        else $error("flag set while guard pin high");

    a_busy_no_ack: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (byte_done && busy) |=> (st_r == ST_IDLE) ##1 !drv_r [*2])
        else $error("byte acknowledged during programming");

    a_flag_hides_code: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (byte_done && ph_r == PH_LEAD && flag_r && !clr_mode_r && rx_byte[7:4] == `EEP_CODE_PROT) |-> !ack_ok)
        else $error("protect code acknowledged with flag set");

    a_ptr_wraps: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (scl_fall && ptr_r == 8'hff && (st_r == ST_TX_NEXT || (st_r == ST_RX_ACK && drv_r && to_rd_r)))
        |=> (ptr_r == 8'h00 && st_r == ST_TX))
        else $error("pointer did not wrap to zero");

    a_nack_releases: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (st_r == ST_TX_ACK && scl_rise && pins_s.sda && !stop_ev && !start_ev)
        |=> (st_r == ST_IDLE && !drv_r))
        else $error("device kept driving after master nack");

    a_restart_keeps_ptr: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (start_ev && !stop_ev) |=> (ptr_r == $past(ptr_r) && !have_r))
        else $error("restart disturbed pointer or kept data");

    a_low_vcc_inhibit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (commit && pins_s.vcc_low) |=> ($stable(flag_r) && !$past(mem_we)))
        else $error("programming under low supply");

    a_clear_needs_cmd: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $fell(flag_r) |-> ($past(kind_r) == K_CLR && $past(commit)))
        else $error("flag cleared without clear command");

endmodule // eep_read_protect
`default_nettype wire

// ==== hdl/eep_params.svh ====
// constants for the serial eeprom read and protection block
// assumes a 200 mhz core clock; included by the package users
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

`define EEP_CODE_ARRAY  4'ha
`define EEP_CODE_PROT   4'h6
`define EEP_CODE_CLR    4'h9
`define EEP_UPPER_BIT   7
`define EEP_PTR_RST     8'h00
`define EEP_FLAG_RST    1'b0
`define EEP_MEM_RST     8'hff
`define EEP_PINS_RST    8'hc0
`define EEP_CLK_NS      5
`define EEP_HV_NS       1000
`define EEP_TWC_MS      5
`define EEP_HV_CYCLES   ((`EEP_HV_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_WC_CYCLES   ((`EEP_TWC_MS * 1000000) / `EEP_CLK_NS)
`define EEP_WC_W        20

`endif

// ==== hdl/eep_pkg.sv ====
// types shared by the eeprom read and protection block
// assumes nothing beyond a systemverilog compiler
package eep_pkg;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic       wp_hv;
        logic       vcc_low;
        logic [2:0] sel;
    } eep_pins_t;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_TX_NEXT} eep_state_t;
    typedef enum logic [1:0] {PH_LEAD, PH_CTRL, PH_ADDR, PH_DATA} eep_phase_t;
    typedef enum logic [1:0] {K_ARRAY, K_SET, K_CLR} eep_kind_t;

endpackage

// ==== hdl/eep_sync.sv ====
// pin input filter: four flip-flops per pin (three stages and a level register), level taken when stages two and three agree
// assumes asynchronous pins and a free running core clock
`timescale 1ns/1ps
`default_nettype none
`include "eep_params.svh"

module eep_sync (
    input  wire logic              core_clk,  // core clock
    input  wire logic              rst_n,     // async reset, active low
    input  wire eep_pkg::eep_pins_t pins_i,   // raw pins
    output var eep_pkg::eep_pins_t pins_o     // filtered levels
);
    import eep_pkg::*;

    localparam logic [7:0] RST_V = `EEP_PINS_RST;

    logic [7:0] raw;
    logic [7:0] filt;
    assign raw    = pins_i;
    assign pins_o = filt;

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_bit
            logic s1_r, s2_r, s3_r, lvl_r;
            logic lvl_nxt;
            always_comb
            begin
                lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
            end
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_r  <= RST_V[g];
                    s2_r  <= RST_V[g];
                    s3_r  <= RST_V[g];
                    lvl_r <= RST_V[g];
                end
                else
                begin
                    s1_r  <= raw[g];
                    s2_r  <= s1_r;
                    s3_r  <= s2_r;
                    lvl_r <= lvl_nxt;
                end
            end
            assign filt[g] = lvl_r;
        end
    endgenerate

endmodule // eep_sync
`default_nettype wire

// ==== sim/eep_bus_master.sv ====
// two-wire bus master model: start, stop, byte send and receive
// assumes a pulled-up data line resolved by the bench; scl idles high between frames
`timescale 1ns/1ps
`default_nettype none

module eep_bus_master (
    input  wire logic core_clk,  // pacing clock
    input  wire logic sda_line,  // resolved data line
    output var logic  scl,       // bus clock, 160 ns period
    output var logic  sda_low    // high while pulling data low
);
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // quarter bit: 8 core clocks, changes land just after an edge
    task automatic q;
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        q();
        scl = 1'b1;
        q();
        r = sda_line;
        q();
        scl = 1'b0;
        q();
    endtask

    // also serves as repeated start from a low clock
    task automatic start;
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask

    task automatic stop;
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // mack low leaves the slot released to end a read
    task automatic recv(output logic [7:0] b, input logic mack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(~mack, r);
    endtask
endmodule // eep_bus_master

`default_nettype wire

// ==== sim/eep_read_protect_tb.sv ====
// self-checking bench for the eeprom read and protection block
// assumes eep_bus_master as bus partner and a short write cycle parameter
`timescale 1ns/1ps
`default_nettype none
`include "eep_params.svh"

module eep_read_protect_tb;
    import eep_pkg::*;
    localparam int         WC  = 400;  // must outlast a start and a control byte after stop
    localparam logic [2:0] SEL = 3'b101;
    localparam logic [7:0] WR  = {`EEP_CODE_ARRAY, SEL, 1'b0};
    localparam logic [7:0] RD  = {`EEP_CODE_ARRAY, SEL, 1'b1};
    localparam logic [7:0] PS  = {`EEP_CODE_PROT, SEL, 1'b0};

    logic      core_clk;
    logic      rst_n;
    logic      wp;
    logic      wp_hv;
    logic      vcc_low;
    logic      scl;
    logic      sda_low;
    logic      sda_line;
    logic      sda_o;
    logic      sda_oe;
    logic      flag;
    logic      busy;
    eep_pins_t pins;
    int        fails;
    int        samples_checked;

    // open drain: pull-up wins unless someone pulls low
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
    assign pins     = {scl, sda_line, wp, wp_hv, vcc_low, SEL};

    eep_read_protect #(.WC_CYCLES(WC)) u_dut (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .pins_i         (pins),
        .sda_o          (sda_o),
        .sda_oe         (sda_oe),
        .protect_flag_o (flag),
        .busy_o         (busy)
    );

    eep_bus_master u_mst (
        .core_clk (core_clk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_low  (sda_low)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000)
        begin
            tick(1);
            n++;
        end
        if (n >= 1000)
        begin
            fails++;
            conclude();
        end
    endtask

    // write frame, optionally led by the 1001 clearing code
    task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                      input logic ea, input logic ld);
        logic k;
        u_mst.start();
        k = 1'b1;
        if (ld)
            u_mst.send({`EEP_CODE_CLR, 4'ha}, k);
        if (k === 1'b1)
            u_mst.send(c, k);
        chk({7'h00, k}, {7'h00, ea});
        if (k === 1'b1)
        begin
            u_mst.send(a, k);
            chk({7'h00, k}, 8'h01);
            u_mst.send(d, k);
            chk({7'h00, k}, 8'h01);
        end
        u_mst.stop();
        if (k === 1'b1)
        begin
            tick(8);
            chk({7'h00, busy}, 8'h01);
            wait_idle();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1, input logic two);
        logic       k;
        logic [7:0] b;
        u_mst.start();
        u_mst.send(WR, k);
        chk({7'h00, k}, 8'h01);
        u_mst.send(a, k);
        u_mst.start();
        u_mst.send(RD, k);
        chk({7'h00, k}, 8'h01);
        u_mst.recv(b, two);
        chk(b, e0);
        if (two)
        begin
            u_mst.recv(b, 1'b0);
            chk(b, e1);
        end
        u_mst.stop();
        tick(8);
        chk({5'h00, sda_o, sda_oe, busy}, 8'h00);
    endtask

    task automatic cur(input logic [7:0] e);
        logic       k;
        logic [7:0] b;
        u_mst.start();
        u_mst.send(RD, k);
        chk({7'h00, k}, 8'h01);
        u_mst.recv(b, 1'b0);
        chk(b, e);
        u_mst.stop();
    endtask

    task automatic t_basics;
        chk({6'h00, flag, busy}, 8'h00);
        cur(8'hff);
        wr({`EEP_CODE_ARRAY, 3'b011, 1'b0}, 8'h00, 8'h00, 1'b0, 1'b0);
        wr({4'h5, SEL, 1'b0}, 8'h00, 8'h00, 1'b0, 1'b0);
        wr({`EEP_CODE_PROT, SEL, 1'b1}, 8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_rw;
        logic k;
        u_mst.start();
        u_mst.send(WR, k);
        u_mst.send(8'h07, k);
        u_mst.send(8'h4b, k);
        u_mst.stop();
        u_mst.start();
        u_mst.send(WR, k);
        chk({7'h00, k}, 8'h00);
        u_mst.stop();
        wait_idle();
        rd(8'h07, 8'h4b, 8'h00, 1'b0);
        cur(8'hff);
    endtask

    task automatic t_seq;
        wr(WR, 8'hff, 8'h5a, 1'b1, 1'b0);
        wr(WR, 8'h00, 8'ha5, 1'b1, 1'b0);
        rd(8'hff, 8'h5a, 8'ha5, 1'b1);
        cur(8'hff);
    endtask

    task automatic t_prot;
        wp = 1'b1;
        wr(WR, 8'h10, 8'h11, 1'b1, 1'b0);
        wr(WR, 8'h90, 8'h22, 1'b1, 1'b0);
        wr(PS, 8'h00, 8'h00, 1'b0, 1'b0);
        chk({7'h00, flag}, 8'h00);
        wp = 1'b0;
        rd(8'h10, 8'hff, 8'h00, 1'b0);
        rd(8'h90, 8'hff, 8'h00, 1'b0);
        vcc_low = 1'b1;
        wr(WR, 8'h30, 8'h99, 1'b1, 1'b0);
        vcc_low = 1'b0;
        rd(8'h30, 8'hff, 8'h00, 1'b0);
    endtask

    task automatic t_flag;
        wr(PS, 8'h00, 8'h00, 1'b1, 1'b0);
        chk({7'h00, flag}, 8'h01);
        wr(WR, 8'h20, 8'h77, 1'b1, 1'b0);
        wr(WR, 8'ha0, 8'h88, 1'b1, 1'b0);
        rd(8'h20, 8'hff, 8'h00, 1'b0);
        rd(8'ha0, 8'h88, 8'h00, 1'b0);
        wr(PS, 8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_clear;
        wr(PS, 8'h00, 8'h00, 1'b0, 1'b1);
        chk({7'h00, flag}, 8'h01);
        wp_hv = 1'b1;
        tick(250);
        wr(PS, 8'h00, 8'h00, 1'b1, 1'b1);
        wp_hv = 1'b0;
        chk({7'h00, flag}, 8'h00);
        wr(WR, 8'h20, 8'h66, 1'b1, 1'b0);
        rd(8'h20, 8'h66, 8'h00, 1'b0);
        wr(PS, 8'h00, 8'h00, 1'b1, 1'b0);
        chk({7'h00, flag}, 8'h01);
    endtask

    initial
    begin
        rst_n           = 1'b0;
        wp              = 1'b0;
        wp_hv           = 1'b0;
        vcc_low         = 1'b0;
        fails           = 0;
        samples_checked = 0;
        tick(6);
        rst_n = 1'b1;
        tick(8);
        t_basics();
        t_rw();
        t_seq();
        t_prot();
        t_flag();
        t_clear();
        conclude();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge core_clk);
        fails++;
        conclude();
    end
endmodule // eep_read_protect_tb

`default_nettype wire
